// >>> rtl/edp_pulse_out.sv
// Encoder divided pulse output: APB registers, divider, origin gating.
// Assumes encoder step, direction and origin strobes on the same clock.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps

// Contract
// R1 - A and B are two pulse trains a quarter period apart.
// R2 - Rotary mode emits the set pulse count per motor revolution on A/B.
// R3 - Linear mode emits at the set output resolution, keeping quadrature.
// R4 - One origin pulse is emitted per revolution.
// R5 - The origin pulse lasts as long as one A pulse level.
// R6 - Reverse rotation setting keeps the same A, B and origin phase form.
// R7 - Origin select 0 gives forward-only origins, 1 gives both, at restart.
// R8 - In forward-only mode the encoder count direction gates the origin.
// R9 - The first forward origin crossing after power-on emits a pulse.
// R10 - After a forward origin pulse every later crossing emits one; the code fires armed reverse crossings only with origin select 1.
// R11 - Reverse crossings emit nothing until a forward one has fired.
// R12 - A direction dependent reference may give origin pulses at two spots.
// R13 - The host should turn two revolutions or go slow before homing.
// R14 - Linear output counts use pitch pulses times four over the setting; the code divides the setting by pitch pulses times four.
// R15 - Every output has a complementary rail that is its exact inverse.
// R16 - A leads B one way, B leads A the other, one phase per step.
module edp_pulse_out
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        i_enc_step,
    input  wire logic        i_enc_up,
    input  wire logic        i_enc_origin,
    output logic             o_quad_a_out,
    output logic             o_quad_a_out_n,
    output logic             o_quad_b_out,
    output logic             o_quad_b_out_n,
    output logic             o_origin_pulse_out,
    output logic             o_origin_pulse_out_n
);

    // Reset release through two flops
    logic       rst_meta_n;
    logic       rst_n;

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Software view of the settings
    logic [3:0]  ctrl;
    logic [31:0] pulses_per_rev_setting;
    logic [12:0] linear_output_resolution_setting;
    logic [31:0] enc_counts_per_rev;
    logic [31:0] pitch_pulses;

    // Active copies, loaded only at restart
    logic        act_linear;
    logic        rotation_direction_select;
    logic        origin_direction_select;
    logic [33:0] act_num;
    logic [33:0] act_den;
    logic        cfg_loaded;

    // APB decode
    logic wr_en;
    logic rd_en;
    logic hit_ctrl;
    logic hit_ppr;
    logic hit_lin;
    logic hit_enc;
    logic hit_pitch;
    logic hit_stat;
    logic hit_pos;
    logic hit_any;
    logic restart;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && !pwrite;
    assign hit_ctrl  = hit(paddr, edp_pkg::CTRL_OFFS);
    assign hit_ppr   = hit(paddr, edp_pkg::PPR_OFFS);
    assign hit_lin   = hit(paddr, edp_pkg::LIN_RES_OFFS);
    assign hit_enc   = hit(paddr, edp_pkg::ENC_RES_OFFS);
    assign hit_pitch = hit(paddr, edp_pkg::PITCH_OFFS);
    assign hit_stat  = hit(paddr, edp_pkg::STATUS_OFFS);
    assign hit_pos   = hit(paddr, edp_pkg::POS_OFFS);
    assign hit_any   = hit_ctrl || hit_ppr || hit_lin || hit_enc
                     || hit_pitch || hit_stat || hit_pos;
    // Zero wait states; unmapped access answers with an error
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !hit_any;
    // Apply bit stands in for a drive restart
    assign restart   = (wr_en && hit_ctrl
                       && pwdata[edp_pkg::CTRL_APPLY_BIT]) || !cfg_loaded;

    // Register writes
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl                             <= edp_pkg::CTRL_RESET;
            pulses_per_rev_setting           <= edp_pkg::PPR_RESET;
            linear_output_resolution_setting <= edp_pkg::LIN_RES_RESET;
            enc_counts_per_rev               <= edp_pkg::ENC_RES_RESET;
            pitch_pulses                     <= edp_pkg::PITCH_RESET;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                ctrl <= {1'b0, pwdata[2:0]};
            if (hit_ppr)
                pulses_per_rev_setting <= pwdata;
            if (hit_lin)
                linear_output_resolution_setting <= pwdata[12:0];
            if (hit_enc)
                enc_counts_per_rev <= pwdata;
            if (hit_pitch)
                pitch_pulses <= pwdata;
        end
    end

    // Divider ratio: edges out per encoder count in
    logic [33:0] next_num;
    logic [33:0] next_den;
    logic [2:0]  wr_ctrl;

    // Settings written with the apply bit take effect in the same write
    assign wr_ctrl  = (wr_en && hit_ctrl) ? pwdata[2:0] : ctrl[2:0];
    assign next_num = wr_ctrl[edp_pkg::CTRL_LINEAR_BIT]
                    ? {21'h0, linear_output_resolution_setting}  // [R3]
                    : {pulses_per_rev_setting, 2'b00};           // [R2]
    assign next_den = wr_ctrl[edp_pkg::CTRL_LINEAR_BIT]
                    ? {pitch_pulses, 2'b00}                      // [R14]
                    : {2'b00, enc_counts_per_rev};               // [R2]

    // Restart load: changes only act here [R7]
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_loaded                <= 1'b0;
            act_linear                <= 1'b0;
            rotation_direction_select <= 1'b0;
            origin_direction_select   <= 1'b0;
            act_num                   <= 34'h0;
            act_den                   <= 34'h1;
        end
        else if (restart)
        begin
            cfg_loaded                <= 1'b1;
            act_linear                <= wr_ctrl[edp_pkg::CTRL_LINEAR_BIT];
            rotation_direction_select <= wr_ctrl[edp_pkg::CTRL_ROTDIR_BIT];
            origin_direction_select   <= wr_ctrl[edp_pkg::CTRL_ORGDIR_BIT];
            act_num                   <= next_num;
            act_den                   <= next_den;
        end
    end

    // Bidirectional divider, residue kept in [0, den)
    logic [34:0] acc;
    logic [34:0] num_x;
    logic [34:0] den_x;
    logic [34:0] sum_up;
    logic        emit_up;
    logic        emit_dn;
    logic        emit;
    logic [34:0] next_acc;
    logic        out_up;

    assign num_x   = {1'b0, act_num};
    assign den_x   = {1'b0, act_den};
    assign sum_up  = acc + num_x;
    assign emit_up = i_enc_step && i_enc_up && (sum_up >= den_x);
    assign emit_dn = i_enc_step && !i_enc_up && (acc < num_x);
    assign emit    = (emit_up || emit_dn) && !restart;
    assign next_acc = !i_enc_step ? acc
                    : i_enc_up    ? (emit_up ? sum_up - den_x : sum_up)
                    : (emit_dn ? acc + den_x - num_x : acc - num_x);
    // Flip the count sense only, so the A/B/C form stays the same [R6]
    assign out_up  = i_enc_up ^ rotation_direction_select;

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc <= 35'h0;
        else if (restart)
            acc <= 35'h0;
        else
            acc <= next_acc;
    end

    // Output position count for software
    logic [31:0] out_pos;

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            out_pos <= 32'h0;
        else if (restart)
            out_pos <= 32'h0;
        else if (emit)
            out_pos <= out_up ? out_pos + 32'h1 : out_pos - 32'h1;
    end

    // Quadrature pair generator [R1] [R16]
    edp_quad_gen u_quad
    (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n),
        .i_step    (emit),
        .i_up      (out_up),
        .o_a       (o_quad_a_out),
        .o_a_n     (o_quad_a_out_n),
        .o_b       (o_quad_b_out),
        .o_b_n     (o_quad_b_out_n)
    );

    // Origin gating; raw encoder direction decides, not the motion
    // setting, and the armed flag survives until restart
    logic armed;
    logic org_fire;
    logic org_fwd;
    logic org_rev;

    assign org_fwd  = i_enc_origin && i_enc_up;                    // [R8]
    assign org_rev  = i_enc_origin && !i_enc_up;
    assign org_fire = org_fwd                                      // [R9]
                    || (org_rev && origin_direction_select
                        && armed);                          // [R10] [R11]

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            armed <= 1'b0;
        else if (org_fwd)
            armed <= 1'b1;                                          // [R9]
        else if (restart)
            armed <= 1'b0;
    end

    // Origin held for two quadrature edges, one A level wide [R5]
    logic [1:0] org_left;
    logic       org_on;
    logic       next_org_on;
    logic [1:0] next_org_left;

    // Each origin event fires anew, so a two-spot reference shows twice
    assign next_org_left = org_fire ? edp_pkg::ORIGIN_EDGES      // [R12]
                         : (emit && org_left != 2'h0)
                           ? org_left - 2'h1 : org_left;
    assign next_org_on   = next_org_left != 2'h0;

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            org_left             <= 2'h0;
            org_on               <= 1'b0;
            o_origin_pulse_out   <= 1'b0;
            o_origin_pulse_out_n <= 1'b1;
        end
        else
        begin
            org_left             <= next_org_left;
            org_on               <= next_org_on;
            o_origin_pulse_out   <= next_org_on;                    // [R4]
            o_origin_pulse_out_n <= ~next_org_on;                   // [R15]
        end
    end

    // Read mux, registered so prdata comes from flops
    logic [31:0] rd_mux;

    assign rd_mux = hit_ctrl  ? {29'h0, ctrl[2:0]}
                  : hit_ppr   ? pulses_per_rev_setting
                  : hit_lin   ? {19'h0, linear_output_resolution_setting}
                  : hit_enc   ? enc_counts_per_rev
                  : hit_pitch ? pitch_pulses
                  : hit_stat  ? {28'h0, org_on, o_quad_b_out,
                                 o_quad_a_out, armed}
                  : hit_pos   ? out_pos
                  : 32'h0;

    // Data loaded in setup so it is steady through the access phase
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0;
        else if (rd_en && !penable)
            prdata <= rd_mux;
    end

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    chk_one_phase: assert property ( // [R16]
        !($changed(o_quad_a_out) && $changed(o_quad_b_out)))
        else $error("A and B changed together");
    chk_up_order: assert property ( // [R16]
        emit && out_up && (o_quad_a_out == o_quad_b_out)
        |=> $changed(o_quad_a_out))
        else $error("Up step did not move A first");
    chk_dn_order: assert property ( // [R16]
        emit && !out_up && (o_quad_a_out == o_quad_b_out)
        |=> $changed(o_quad_b_out))
        else $error("Down step did not move B first");
    chk_idle_still: assert property ( // [R2]
        !emit |=> $stable(o_quad_a_out) && $stable(o_quad_b_out))
        else $error("Quadrature moved without a step");
    chk_rails_pair: assert property ( // [R15]
        (o_quad_a_out_n == !o_quad_a_out)
        && (o_quad_b_out_n == !o_quad_b_out)
        && (o_origin_pulse_out_n == !o_origin_pulse_out))
        else $error("Complement rail mismatch");
    chk_fwd_fires: assert property ( // [R9]
        org_fwd |=> o_origin_pulse_out)
        else $error("Forward origin did not pulse");
    chk_rev_blocked: assert property ( // [R11]
        org_rev && !armed && !emit && !org_on |=> !o_origin_pulse_out)
        else $error("Reverse origin fired before arming");
    chk_rev_armed: assert property ( // [R10]
        org_rev && armed && origin_direction_select
        |=> o_origin_pulse_out)
        else $error("Armed reverse origin missed");
    chk_fwd_only: assert property ( // [R7]
        org_rev && !origin_direction_select && !org_on && !emit
        |=> !o_origin_pulse_out)
        else $error("Reverse origin in forward-only mode");
    chk_origin_width: assert property ( // [R5]
        org_fire ##1 (!emit && !i_enc_origin) [*2]
        |-> o_origin_pulse_out)
        else $error("Origin pulse ended without edges");
    chk_bus_ready: assert property (
        psel && penable |-> pready)
        else $error("Slave stalled");

    cov_rev_armed: cover property (org_rev && armed && org_fire);
    cov_restart: cover property (wr_en && hit_ctrl && restart);
    cov_down_step: cover property (emit && !out_up);
    cov_origin_end: cover property (org_on ##1 !org_on);

endmodule // edp_pulse_out

// >>> rtl/edp_pkg.sv
// Constants for the encoder divided pulse output block.
// Assumes a 32-bit APB bus and byte addresses in the word offsets.
package edp_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFS      = 8'h00;
    localparam logic [7:0] PPR_OFFS       = 8'h04;
    localparam logic [7:0] LIN_RES_OFFS   = 8'h08;
    localparam logic [7:0] ENC_RES_OFFS   = 8'h0C;
    localparam logic [7:0] PITCH_OFFS     = 8'h10;
    localparam logic [7:0] STATUS_OFFS    = 8'h14;
    localparam logic [7:0] POS_OFFS       = 8'h18;

    // Control field positions
    localparam int CTRL_LINEAR_BIT  = 0;
    localparam int CTRL_ROTDIR_BIT  = 1;
    localparam int CTRL_ORGDIR_BIT  = 2;
    localparam int CTRL_APPLY_BIT   = 3;

    // Status field positions
    localparam int STAT_ARMED_BIT   = 0;
    localparam int STAT_A_BIT       = 1;
    localparam int STAT_B_BIT       = 2;
    localparam int STAT_C_BIT       = 3;

    // Values after reset
    localparam logic [3:0]  CTRL_RESET    = 4'h0;
    localparam logic [31:0] PPR_RESET     = 32'h0000_0800;
    localparam logic [12:0] LIN_RES_RESET = 13'h0014;
    localparam logic [31:0] ENC_RES_RESET = 32'h0100_0000;
    localparam logic [31:0] PITCH_RESET   = 32'h0000_0100;

    // Quadrature edges per origin pulse: half an A period
    localparam logic [1:0]  ORIGIN_EDGES  = 2'h2;

endpackage

// >>> rtl/edp_quad_gen.sv
// Quadrature step generator: one output edge per step request.
// Assumes step and dir come from logic on the same clock.
`timescale 1ns/10ps
module edp_quad_gen
(
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_step,
    input  wire logic i_up,
    output logic      o_a,
    output logic      o_a_n,
    output logic      o_b,
    output logic      o_b_n
);

    logic [1:0] phase;
    logic [1:0] next_phase;
    logic       next_a;
    logic       next_b;

    // Gray walk 00,10,11,01: up lets A lead, down lets B lead [R16]
    assign next_phase = !i_step ? phase
                      : i_up   ? phase + 2'h1
                      :          phase - 2'h1;
    assign next_a = (next_phase == 2'h1) || (next_phase == 2'h2); // [R1]
    assign next_b = (next_phase == 2'h2) || (next_phase == 2'h3); // [R1]

    // Both rails of each pair from their own flop [R15]
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase <= 2'h0;
            o_a   <= 1'b0;
            o_a_n <= 1'b1;
            o_b   <= 1'b0;
            o_b_n <= 1'b1;
        end
        else
        begin
            phase <= next_phase;
            o_a   <= next_a;
            o_a_n <= ~next_a;
            o_b   <= next_b;
            o_b_n <= ~next_b;
        end
    end

endmodule // edp_quad_gen

// >>> dv/edp_host_model.sv
// Host side model: counts quadrature edges and origin pulses.
// Assumes all pins are sampled on the drive's own clock.
`timescale 1ns/10ps
module edp_host_model
(
    input  wire logic               i_sys_clk,
    input  wire logic               i_resetn,
    input  wire logic               i_a,
    input  wire logic               i_a_n,
    input  wire logic               i_b,
    input  wire logic               i_b_n,
    input  wire logic               i_c,
    input  wire logic               i_c_n,
    output logic signed [31:0]      o_pos,
    output logic        [7:0]       o_orgs,
    output logic        [7:0]       o_width,
    output logic        [7:0]       o_errs
);
    logic [1:0] prev_idx;
    logic       prev_c;
    logic [7:0] run;
    // Gray index 00,10,11,01 maps to 0..3, so a step is a difference of one
    wire  [1:0] idx  = {i_b, i_a ^ i_b};
    wire  [1:0] diff = idx - prev_idx;
    wire        moved = (diff != 2'h0);

    // Decode, count, and flag illegal phase jumps or broken rails
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            prev_idx <= 2'h0;
            prev_c   <= 1'b0;
            run      <= 8'h00;
            o_pos    <= 32'sh0;
            o_orgs   <= 8'h00;
            o_width  <= 8'h00;
            o_errs   <= 8'h00;
        end
        else
        begin
            prev_idx <= idx;
            prev_c   <= i_c;
            if (diff == 2'h1)
                o_pos <= o_pos + 32'sh1;
            else if (diff == 2'h3)
                o_pos <= o_pos - 32'sh1;
            if (diff == 2'h2 || i_a_n == i_a || i_b_n == i_b || i_c_n == i_c)
                o_errs <= o_errs + 8'h01;
            if (i_c && !prev_c)
            begin
                o_orgs <= o_orgs + 8'h01;
                run    <= 8'h00;
            end
            else if (prev_c && moved)
                run <= run + 8'h01;
            // Edge on the falling sample still belongs to the pulse
            if (!i_c && prev_c)
                o_width <= run + {7'h00, moved};
        end
    end
endmodule // edp_host_model

// >>> dv/encoder_divided_pulse_output_tb_top.sv
// Self-checking bench for the divided pulse output block.
// Assumes the host model file is compiled before this one.
`timescale 1ns/10ps
module encoder_divided_pulse_output_tb_top;
    logic        i_sys_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] seed = 32'h0000_4E2A;
    logic        i_enc_step = 1'b0;
    logic        i_enc_up = 1'b0;
    logic        i_enc_origin = 1'b0;
    logic        snap = 1'b0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         qa, qan, qb, qbn, qc, qcn;
    wire  signed [31:0] h_pos;
    wire  [7:0]  h_orgs, h_width, h_errs;
    logic [32:0] q_rd[$];
    logic [55:0] q_host[$];
    int          n_fail = 0;
    int          compares = 0;

    always #50 i_sys_clk = ~i_sys_clk;

    edp_pulse_out i_edp_pulse_out
    (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_enc_step(i_enc_step),
        .i_enc_up(i_enc_up), .i_enc_origin(i_enc_origin),
        .o_quad_a_out(qa), .o_quad_a_out_n(qan),
        .o_quad_b_out(qb), .o_quad_b_out_n(qbn),
        .o_origin_pulse_out(qc), .o_origin_pulse_out_n(qcn)
    );

    edp_host_model i_edp_host_model
    (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_a(qa),
        .i_a_n(qan), .i_b(qb), .i_b_n(qbn), .i_c(qc), .i_c_n(qcn),
        .o_pos(h_pos), .o_orgs(h_orgs), .o_width(h_width),
        .o_errs(h_errs)
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_host(input logic [55:0] got, input logic [55:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Results are matched to the oldest note as they appear
    always @(posedge i_sys_clk)
    begin
        if (psel && penable && pready && !pwrite)
            cmp_rd({pslverr, prdata}, q_rd.pop_front());
        if (snap)
            cmp_host({h_pos, h_orgs, h_width, h_errs}, q_host.pop_front());
    end

    // APB transfer; held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            q_rd.push_back(e);
        @(posedge i_sys_clk);
        penable <= 1'b1;
        // No assumed latency; a stalled slave is left to the watchdog
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask

    // Restart so that new settings take hold; restart cycle drops steps
    task automatic restart(input logic [31:0] ctrl);
        apb(1'b1, edp_pkg::CTRL_OFFS, ctrl | 32'h8, 33'h0);
        repeat (3) @(posedge i_sys_clk);
    endtask

    // Random spacing, back-to-back steps included
    task automatic steps(input int n, input logic up);
        logic [31:0] r;
        int          k;
        k = 0;
        while (k < n)
        begin
            @(posedge i_sys_clk);
            r = xs();
            i_enc_step <= r[0] | r[1];
            i_enc_up <= up;
            if (r[0] | r[1])
                k++;
        end
        @(posedge i_sys_clk);
        i_enc_step <= 1'b0;
    endtask

    // Origin strobe, then one full revolution to finish the pulse
    task automatic org(input logic up);
        @(posedge i_sys_clk);
        i_enc_origin <= 1'b1;
        i_enc_up <= up;
        @(posedge i_sys_clk);
        i_enc_origin <= 1'b0;
        steps(64, up);
    endtask

    task automatic expect_host(input int pos, input logic [7:0] orgs,
                               input logic [7:0] w);
        repeat (4) @(posedge i_sys_clk);
        q_host.push_back({pos[31:0], orgs, w, 8'h00});
        snap <= 1'b1;
        @(posedge i_sys_clk);
        snap <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence; 4 pulses per rev over 64 counts
    initial
    begin
        repeat (12) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        rd(edp_pkg::CTRL_OFFS, 33'h0);
        rd(edp_pkg::PPR_OFFS, 33'h0_0000_0800);
        rd(edp_pkg::LIN_RES_OFFS, 33'h0_0000_0014);
        rd(edp_pkg::ENC_RES_OFFS, 33'h0_0100_0000);
        rd(edp_pkg::PITCH_OFFS, 33'h0_0000_0100);
        apb(1'b1, 8'h1C, 32'h5, 33'h0);
        rd(8'h1C, 33'h1_0000_0000);
        $display("test reset values done");
        apb(1'b1, edp_pkg::PPR_OFFS, 32'h4, 33'h0);
        apb(1'b1, edp_pkg::ENC_RES_OFFS, 32'h40, 33'h0);
        restart(32'h0);
        steps(128, 1'b1);
        expect_host(32'h20, 8'h00, 8'h00);
        apb(1'b1, edp_pkg::STATUS_OFFS, 32'hF, 33'h0);
        rd(edp_pkg::STATUS_OFFS, 33'h0);
        rd(edp_pkg::POS_OFFS, 33'h0_0000_0020);
        rd(edp_pkg::CTRL_OFFS, 33'h0);
        $display("test rotary count done");
        org(1'b0);
        org(1'b1);
        org(1'b0);
        expect_host(32'h10, 8'h01, 8'h02);
        rd(edp_pkg::STATUS_OFFS, 33'h1);
        $display("test forward origin done");
        // Select written without apply: stored, but not yet active
        apb(1'b1, edp_pkg::CTRL_OFFS, 32'h4, 33'h0);
        rd(edp_pkg::CTRL_OFFS, 33'h0_0000_0004);
        org(1'b0);
        expect_host(32'h0, 8'h01, 8'h02);
        $display("test restart gating done");
        restart(32'h4);
        rd(edp_pkg::STATUS_OFFS, 33'h0);
        org(1'b0);
        org(1'b1);
        org(1'b0);
        expect_host(-32'h10, 8'h03, 8'h02);
        $display("test both origin done");
        restart(32'h2);
        steps(64, 1'b1);
        org(1'b1);
        expect_host(-32'h30, 8'h04, 8'h02);
        $display("test reverse done");
        apb(1'b1, edp_pkg::LIN_RES_OFFS, 32'h14, 33'h0);
        apb(1'b1, edp_pkg::PITCH_OFFS, 32'h8, 33'h0);
        restart(32'h1);
        steps(32, 1'b1);
        expect_host(-32'h1C, 8'h04, 8'h02);
        steps(64, 1'b1);
        expect_host(32'hC, 8'h04, 8'h02);
        $display("test linear done");
        wrap_up();
    end

    // Hang guard, about sixteen times the expected run
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        n_fail++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule // encoder_divided_pulse_output_tb_top
